// ---- ihrp_port.sv ----
/*
  Eight-register host port giving indirect access to an 11-bit address,
  32-bit data internal space, plus channel run control and sync issue.
  Assumes host pins are synchronous to clk_i and the internal space
  answers a read with valid data two cycles after the request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ihrp_cfg.svh"

// Behaviour
// - Three-bit address, eight-bit two-way data bus
// - Internal address 11 bits, data 32 bits
// - High register bits 2:0 give address 10:8
// - High bit 6 read increment, 7 write
// - Lane 0 write launches internal write
// - Lane 0 read launches read, loads lanes
// - Other lanes read without new access
// - Lane 0 low byte, lane 3 top
// - Internal access lasts two clock cycles
// - Run and sync writes act at once
// - One write sets all run control bits
// - Start sync clears channel's control bits
// - Bits 7:4 permit channel memory loading
// - Bits 3:0 wake channel, low sleeps
// - Sync write issues beam, hop, start
// - Many accesses while chip select low
// - Separate strobes: ready low from start until completion
// - Data strobe style: acknowledge low at end, high after strobe
// - Acknowledge is open drain
module ihrp_port import ihrp_pkg::*; #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 32
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Host pins
  input wire logic style_sel_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] host_addr_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n_o,
  output logic ready_o,
  output logic access_acknowledge_out_o,
  output logic access_acknowledge_oe_n_o,
  // Internal register space
  output ihrp_req_t req_o,
  input wire logic [31:0] int_rdata_i,
  // Channel control
  output logic [3:0] coefficient_memory_load_o,
  output logic [3:0] channel_awake_o,
  output ihrp_sync_t sync_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W != 11 || DATA_W != 32) begin : g_bad
    $error("ihrp_port serves only 11-bit address and 32-bit data");
  end

  // ----------------------------------------------------------------
  // Host strobe decode
  // ----------------------------------------------------------------
  logic strobe; // Access strobe level, either style
  logic is_read; // Direction of current strobe
  logic strobe_q; // Strobe of previous cycle
  logic start_acc; // First cycle of an access

  always_comb begin
    if (style_sel_i) begin
      // Data strobe plus direction
      strobe = !cs_n_i && !rd_n_i;
      is_read = wr_n_i;
    end else begin
      // Separate read and write strobes
      strobe = !cs_n_i && (!rd_n_i || !wr_n_i);
      is_read = !rd_n_i;
    end
  end
  // Chip select may stay low; each strobe edge is one access
  assign start_acc = strobe && !strobe_q;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] lane [4]; // Data lanes, lane 0 lowest
  logic [7:0] addr_lo, addr_hi; // Address registers
  logic [7:0] run_ctl; // Channel run control
  ihrp_state_t state; // Sequencer state
  logic [1:0] cnt; // Internal cycle counter
  logic acc_rd; // Launched access is a read
  logic rd_hold; // Read data held after completion
  ihrp_sync_t sync_q; // Sync strobes, one cycle
  logic [7:0] dout; // Registered read data

  logic [7:0] next_lane [4];
  logic [7:0] next_addr_lo, next_addr_hi, next_run_ctl, next_dout;
  ihrp_state_t next_state;
  logic [1:0] next_cnt;
  logic next_acc_rd, next_strobe_q;
  ihrp_sync_t next_sync;
  ihrp_req_t next_req;
  logic [10:0] cur_addr, inc_addr;
  logic done;

  assign cur_addr = {addr_hi[2:0], addr_lo};
  assign inc_addr = cur_addr + 11'h001;
  assign done = (state == IHRP_BUSY) && (cnt == 2'(`IHRP_ACCESS_CYCLES - 1));

  // Next values for all host-side state
  always_comb begin
    next_lane = lane;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_run_ctl = run_ctl;
    next_dout = dout;
    next_state = state;
    next_cnt = cnt;
    next_acc_rd = acc_rd;
    next_strobe_q = strobe;
    next_sync = '0;
    next_req = '0;
    case (state)
      IHRP_IDLE: begin
        if (start_acc && is_read) begin
          // Reads return the addressed byte
          case (host_addr_i)
            `IHRP_OFS_LANE1: next_dout = lane[1];
            `IHRP_OFS_LANE2: next_dout = lane[2];
            `IHRP_OFS_LANE3: next_dout = lane[3];
            `IHRP_OFS_RUN: next_dout = run_ctl;
            `IHRP_OFS_ADDR_LO: next_dout = addr_lo;
            `IHRP_OFS_ADDR_HI: next_dout = addr_hi;
            default: next_dout = `IHRP_RST_BYTE; // Sync is write only
          endcase
          if (host_addr_i == `IHRP_OFS_LANE0) begin
            // Launch the internal read
            next_req.rd = 1'b1;
            next_req.addr = cur_addr;
            next_acc_rd = 1'b1;
            next_cnt = 2'h0;
            next_state = IHRP_BUSY;
          end else begin
            next_state = IHRP_HOLD;
          end
        end else if (start_acc) begin
          case (host_addr_i)
            `IHRP_OFS_LANE1: next_lane[1] = host_data_i;
            `IHRP_OFS_LANE2: next_lane[2] = host_data_i;
            `IHRP_OFS_LANE3: next_lane[3] = host_data_i;
            `IHRP_OFS_RUN: next_run_ctl = host_data_i;
            `IHRP_OFS_SYNC: begin
              // Sync strobes leave at once per selected channel
              next_sync.start = host_data_i[`IHRP_SYNC_START] ? host_data_i[3:0] : 4'h0;
              next_sync.hop = host_data_i[`IHRP_SYNC_HOP] ? host_data_i[3:0] : 4'h0;
              next_sync.beam = host_data_i[`IHRP_SYNC_BEAM] ? host_data_i[3:0] : 4'h0;
            end
            `IHRP_OFS_ADDR_LO: next_addr_lo = host_data_i;
            `IHRP_OFS_ADDR_HI: next_addr_hi = host_data_i;
            default: next_lane[0] = host_data_i;
          endcase
          if (host_addr_i == `IHRP_OFS_LANE0) begin
            // Lane 0 is the last byte staged; launch the write
            next_req.wr = 1'b1;
            next_req.addr = cur_addr;
            next_req.wdata = {lane[3], lane[2], lane[1], host_data_i};
            next_acc_rd = 1'b0;
            next_cnt = 2'h0;
            next_state = IHRP_BUSY;
          end else begin
            next_state = IHRP_HOLD;
          end
        end
      end
      IHRP_BUSY: begin
        next_cnt = cnt + 2'h1;
        if (done) begin
          if (acc_rd) begin
            // Fill all lanes from the word
            next_lane[0] = int_rdata_i[7:0];
            next_lane[1] = int_rdata_i[15:8];
            next_lane[2] = int_rdata_i[23:16];
            next_lane[3] = int_rdata_i[31:24];
            next_dout = int_rdata_i[7:0];
          end
          // Increment once the access is finished
          if ((acc_rd && addr_hi[`IHRP_HI_RDINC]) || (!acc_rd && addr_hi[`IHRP_HI_WRINC])) begin
            next_addr_lo = inc_addr[7:0];
            next_addr_hi = {addr_hi[7:3], inc_addr[10:8]};
          end
          next_state = IHRP_HOLD;
        end
      end
      IHRP_HOLD: begin
        // Wait for the host to drop its strobe
        if (!strobe) begin
          next_state = IHRP_IDLE;
        end
      end
      default: next_state = IHRP_IDLE;
    endcase
    // Start sync clears the channel's wake and load bits
    for (int ch = 0; ch < 4; ch++) begin
      if (next_sync.start[ch]) begin
        next_run_ctl[ch] = 1'b0;
        next_run_ctl[ch + 4] = 1'b0;
      end
    end
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        lane[i] <= `IHRP_RST_BYTE;
      end
      addr_lo <= `IHRP_RST_BYTE;
      addr_hi <= `IHRP_RST_BYTE;
      run_ctl <= `IHRP_RST_BYTE;
      dout <= `IHRP_RST_BYTE;
      state <= IHRP_IDLE;
      cnt <= 2'h0;
      acc_rd <= 1'b0;
      strobe_q <= 1'b0;
      sync_q <= '0;
      req_o <= '0;
    end else if (ce_i) begin
      lane <= next_lane;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      run_ctl <= next_run_ctl;
      dout <= next_dout;
      state <= next_state;
      cnt <= next_cnt;
      acc_rd <= next_acc_rd;
      strobe_q <= next_strobe_q;
      sync_q <= next_sync;
      req_o <= next_req;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_hold = (state == IHRP_HOLD) && is_read;
  assign host_data_o = dout;
  assign host_data_oe_n_o = !(strobe && is_read && rd_hold);
  // Ready low while a separate-strobe access is being served
  assign ready_o = !(!style_sel_i && strobe && state != IHRP_HOLD);
  // Acknowledge only pulls low; released line floats high
  assign access_acknowledge_out_o = 1'b0;
  assign access_acknowledge_oe_n_o = !(style_sel_i && state == IHRP_HOLD && strobe);
  assign coefficient_memory_load_o = run_ctl[7:4];
  assign channel_awake_o = run_ctl[3:0];
  assign sync_o = sync_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_launch;
    ce_i && state == IHRP_IDLE && start_acc && host_addr_i == `IHRP_OFS_LANE0;
  endsequence

  launch_length_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_launch ##1 ce_i [*2] |=> state == IHRP_HOLD)
    else $error("internal access not two cycles");
  write_launch_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_launch and !is_read) |=> req_o.wr && req_o.wdata[7:0] == $past(host_data_i))
    else $error("lane 0 write did not launch");
  read_launch_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_launch and is_read) |=> req_o.rd && !req_o.wr)
    else $error("lane 0 read did not launch");
  other_lane_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && start_acc && host_addr_i != `IHRP_OFS_LANE0 |=> !req_o.rd && !req_o.wr)
    else $error("other lane launched access");
  run_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && state == IHRP_IDLE && start_acc && !is_read && host_addr_i == `IHRP_OFS_RUN
    |=> run_ctl == $past(host_data_i))
    else $error("run control write lost");
  start_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && |next_sync.start |=> (run_ctl[3:0] & $past(next_sync.start)) == 4'h0)
    else $error("start sync left bits set");
  sync_issue_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && state == IHRP_IDLE && start_acc && !is_read && host_addr_i == `IHRP_OFS_SYNC
    && host_data_i[`IHRP_SYNC_HOP] |=> sync_o.hop == $past(host_data_i[3:0]))
    else $error("hop sync not issued");
  ack_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !strobe |-> access_acknowledge_oe_n_o)
    else $error("acknowledge held after strobe");
  // Ready stays low through the last busy cycle while the host waits
  ready_busy_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_launch and !style_sel_i) ##1 (ce_i && strobe) [*2] |-> !ready_o)
    else $error("ready released before completion");
  addr_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && done && !acc_rd && addr_hi[`IHRP_HI_WRINC] |=> cur_addr == $past(inc_addr))
    else $error("write increment missing");

endmodule

`default_nettype wire

// ---- ihrp_cfg.svh ----
/*
  Constants for the indirect host register port: external offsets,
  field positions, reset values and the internal access length.
  Assumes inclusion by bare name from the package and the port module.
*/
`ifndef IHRP_CFG_SVH
`define IHRP_CFG_SVH

// ----------------------------------------------------------------
// External register offsets
// ----------------------------------------------------------------
`define IHRP_OFS_LANE0 3'h0
`define IHRP_OFS_LANE1 3'h1
`define IHRP_OFS_LANE2 3'h2
`define IHRP_OFS_LANE3 3'h3
`define IHRP_OFS_RUN 3'h4
`define IHRP_OFS_SYNC 3'h5
`define IHRP_OFS_ADDR_LO 3'h6
`define IHRP_OFS_ADDR_HI 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IHRP_HI_RDINC 6
`define IHRP_HI_WRINC 7
`define IHRP_SYNC_START 4
`define IHRP_SYNC_HOP 5
`define IHRP_SYNC_BEAM 6

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define IHRP_RST_BYTE 8'h00
`define IHRP_RST_ADDR 11'h000
`define IHRP_RST_WORD 32'h0000_0000
`define IHRP_ACCESS_CYCLES 2

`endif

// ---- ihrp_pkg.sv ----
/*
  Types shared by the indirect host register port.
  Assumes ihrp_cfg.svh is on the include path.
*/
`include "ihrp_cfg.svh"

package ihrp_pkg;
  // Internal access request toward the register space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [10:0] addr;
    logic [31:0] wdata;
  } ihrp_req_t;

  // Sync strobes toward the four channels
  typedef struct packed {
    logic [3:0] start;
    logic [3:0] hop;
    logic [3:0] beam;
  } ihrp_sync_t;

  // Port sequencing states
  typedef enum logic [1:0] {
    IHRP_IDLE,
    IHRP_BUSY,
    IHRP_HOLD
  } ihrp_state_t;
endpackage

// ---- ihrp_space.sv ----
/*
  Behavioural internal register space behind the host port.
  Assumes one shared clock and one-cycle request pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module ihrp_space import ihrp_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Request in, read word out
  input wire ihrp_req_t req_i,
  output logic [31:0] rdata_o
);
  // ------------------------------------------------
  // Storage
  // ------------------------------------------------
  logic [31:0] mem [2048]; // Word store, 11-bit address
  logic [31:0] last = 32'h0; // Word of the last read
  int age = 9; // Edges since the read launch
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
  end
  // Writes land, reads start the hold timer
  always @(posedge clk_i) begin
    if (req_i.wr) mem[req_i.addr] <= req_i.wdata;
    if (req_i.rd) begin
      last <= mem[req_i.addr];
      age <= 0;
    end else begin
      age <= age + 1;
    end
  end
  // Stale word inverted so a late sample cannot pass
  assign rdata_o = (age < 3) ? last : ~last;
endmodule
`default_nettype wire

// ---- indirect_host_register_port_test.sv ----
/*
  Self-checking bench for ihrp_port against a word-level model.
  Assumes ihrp_space stands in for the internal register space.
*/
`timescale 1ns/1ps
`default_nettype none
module indirect_host_register_port_test;
  import ihrp_pkg::*;
  // ------------------------------------------------
  // Pins and model state
  // ------------------------------------------------
  logic clk_i, rstn_i, style, cs_n, rd_n, wr_n, ce;
  logic [2:0] ha;
  logic [7:0] hd, q_o, run, lo, hi;
  logic q_oe_n, ready, ack, ack_oe_n;
  ihrp_req_t req;
  logic [31:0] rdata, b;
  logic [3:0] load, awake;
  ihrp_sync_t sy, sacc; // Sync pulses, accumulated
  logic [7:0] ln [4]; // Staged lanes
  logic [31:0] mdl [int]; // Internal words
  logic [2:0] rs [7] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h0, 3'h6, 3'h7};
  int num_errors = 0;
  int n_checks = 0;
  ihrp_port u_ihrp_port (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
    .style_sel_i(style), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .host_addr_i(ha), .host_data_i(hd), .host_data_o(q_o),
    .host_data_oe_n_o(q_oe_n), .ready_o(ready), .access_acknowledge_out_o(ack),
    .access_acknowledge_oe_n_o(ack_oe_n), .req_o(req), .int_rdata_i(rdata),
    .coefficient_memory_load_o(load), .channel_awake_o(awake), .sync_o(sy));
  ihrp_space u_ihrp_space (.clk_i(clk_i), .req_i(req), .rdata_o(rdata));
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Pulses are one cycle, so collect them
  always @(posedge clk_i) sacc <= sacc | sy;
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Model address increment, 11-bit wrap
  task automatic bump();
    {hi[2:0], lo} = {hi[2:0], lo} + 11'h1;
  endtask
  // One host access; direction pin and write strobe share wr_n
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(negedge clk_i);
    ha <= a;
    hd <= d;
    rd_n <= w & ~style;
    wr_n <= ~w;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (n < 12 && (style ? ack_oe_n !== 1'b0 : ready !== 1'b1));
    chk(n, (a == 3'h0) ? 3 : 1);
    if (style) chk(ack, 1'b0);
    if (!w) chk(q_oe_n, 1'b0);
    q = q_o;
    @(negedge clk_i);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk_i);
    #1 chk({ack_oe_n, q_oe_n}, 2'b11);
  endtask
  // Enable low: a full write strobe must leave the run bits alone
  task automatic freeze();
    @(negedge clk_i);
    ce <= 1'b0;
    ha <= 3'h4;
    hd <= ~run;
    rd_n <= ~style;
    wr_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk({load, awake}, run);
    @(negedge clk_i);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(negedge clk_i);
    ce <= 1'b1;
    @(posedge clk_i);
    #1 chk({load, awake}, run);
  endtask
  // Access plus model update and compare
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [31:0] e;
    sacc = '0;
    acc(w, a, d, q);
    if (w) begin
      case (a)
        3'h0: begin
          ln[0] = d;
          mdl[{hi[2:0], lo}] = {ln[3], ln[2], ln[1], ln[0]};
          if (hi[7]) bump();
        end
        3'h4: run = d;
        3'h5: begin
          for (int c = 0; c < 4; c++) if (d[4] && d[c]) {run[c + 4], run[c]} = 2'b00;
          chk(sacc, {d[3:0] & {4{d[4]}}, d[3:0] & {4{d[5]}}, d[3:0] & {4{d[6]}}});
        end
        3'h6: lo = d;
        3'h7: hi = d;
        default: ln[a[1:0]] = d;
      endcase
      chk({load, awake}, run);
    end else begin
      if (a == 3'h0) begin
        e = mdl.exists({hi[2:0], lo}) ? mdl[{hi[2:0], lo}] : 32'h0;
        {ln[3], ln[2], ln[1], ln[0]} = e;
        if (hi[6]) bump();
      end
      case (a)
        3'h4: e = run;
        3'h5: e = 32'h0;
        3'h6: e = lo;
        3'h7: e = hi;
        default: e = ln[a[1:0]];
      endcase
      chk(q, e);
    end
  endtask
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    ce = 1'b1;
    style = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ha = 3'h0;
    hd = 8'h00;
    sacc = '0;
    {run, lo, hi} = 24'h0;
    ln = '{default: 8'h00};
    void'($urandom(32'h5bd9));
    repeat (16) @(negedge clk_i);
    rstn_i <= 1'b1;
    cs_n <= 1'b0; // Held low for every access
    @(posedge clk_i);
    #1 chk({ready, ack_oe_n, q_oe_n, load, awake, req.rd, req.wr}, {3'b111, 10'h0});
    for (int s = 0; s < 2; s++) begin
      @(negedge clk_i);
      style <= s[0];
      op(1'b1, 3'h4, 8'($urandom));
      op(1'b0, 3'h4, 8'h00);
      freeze();
      op(1'b1, 3'h5, 8'h14);
      op(1'b1, 3'h5, 8'($urandom));
      op(1'b1, 3'h5, 8'h00);
      op(1'b0, 3'h5, 8'h00);
      for (int m = 0; m < 4; m++) begin
        b = $urandom;
        op(1'b1, 3'h6, b[7:0]);
        op(1'b1, 3'h7, {m[1:0], b[13:8]});
        for (int i = 3; i >= 0; i--) op(1'b1, i[2:0], 8'($urandom));
        op(1'b1, 3'h0, 8'($urandom));
        op(1'b1, 3'h7, {m[1:0], b[13:8]});
        op(1'b1, 3'h6, b[7:0]);
        foreach (rs[k]) op(1'b0, rs[k], 8'h00);
      end
    end
    summarize();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
